// File: rtl/bfau_unit.sv
// Bit-field operations and effective address generation, one cycle
`timescale 1ns/1ps
module bfau_unit
    import bfau_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Issue from the sequencer
    input wire logic i_valid,
    input wire logic [3:0] i_op,
    input wire logic i_field_from_reg,
    input wire logic [4:0] i_field_width,
    input wire logic [4:0] i_field_offset,
    input wire logic [1:0] i_addr_mode,
    input wire logic [1:0] i_size,
    input wire logic [15:0] i_imm16,
    // Register file operands
    input wire logic [31:0] i_first_source_reg,
    input wire logic [31:0] i_second_source_reg,
    input wire logic [31:0] i_dest_reg,
    // Registered results
    output logic o_result_valid,
    output logic [31:0] o_result,
    output logic o_mem_valid,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    output logic o_mem_write,
    output logic o_mem_read,
    output logic o_illegal
);

    // ****************************************************************
    // Field selection
    // ****************************************************************
    logic [4:0] offs;
    logic [4:0] wraw;
    logic [5:0] width;
    // Register form: bits 4..0 offset, bits 9..5 width
    assign offs = i_field_from_reg ? i_second_source_reg[4:0]
                                   : i_field_offset;
    assign wraw = i_field_from_reg ? i_second_source_reg[9:5]
                                   : i_field_width;
    // Zero encodes all 32 bits, hence the extra width bit
    assign width = (wraw == 5'h00) ? BFAU_FULL_WIDTH
                                   : {1'b0, wraw};

    // Mask of width ones at bit zero; 64-bit shift keeps width 32 legal
    logic [63:0] low_ones_w;
    logic [31:0] low_ones;
    logic [31:0] fmask;
    assign low_ones_w = (64'h1 << width) - 64'h1;
    assign low_ones = low_ones_w[31:0];
    // Fields past bit 31 are cut off at the word's top
    assign fmask = low_ones << offs;

    // ****************************************************************
    // Bit-field results
    // ****************************************************************
    logic [31:0] src1;
    logic [31:0] r_clr;
    logic [31:0] r_set;
    logic [31:0] shr;
    logic [31:0] r_extu;
    logic [31:0] r_ext;
    logic [5:0] top_idx;
    logic sign_bit;
    logic [4:0] ext_top;
    logic [31:0] ext_keep;
    logic [31:0] r_mak;
    logic [63:0] rot_w;
    logic [31:0] r_rot;
    logic [5:0] ff0_pos;
    logic [5:0] ff1_pos;
    assign src1 = i_first_source_reg;
    assign r_clr = src1 & ~fmask;
    assign r_set = src1 | fmask;
    assign shr = src1 >> offs;
    assign r_extu = shr & low_ones;
    // Top bit of the field, clamped at 31 when it runs off the word
    assign top_idx = (({1'b0, offs} + width) > 6'h20) ? 6'h1f
                   : 6'({1'b0, offs} + width - 6'h1);
    assign sign_bit = src1[top_idx[4:0]];
    // Fill above the bits really taken, so a cut field still sign-extends
    assign ext_top = top_idx[4:0] - offs;
    assign ext_keep = 32'hffff_ffff >> (5'h1f - ext_top);
    assign r_ext = sign_bit ? (r_extu | ~ext_keep)
                            : r_extu;
    assign r_mak = (src1 & low_ones) << offs;
    assign rot_w = {src1, src1} >> offs;
    assign r_rot = rot_w[31:0];

    // Find-first scans on the second source operand
    bfau_find_first #(.WIDTH(BFAU_XLEN)) u_ff0 (
        .i_value(i_second_source_reg),
        .i_seek_one(1'b0),
        .o_position(ff0_pos)
    );
    bfau_find_first #(.WIDTH(BFAU_XLEN)) u_ff1 (
        .i_value(i_second_source_reg),
        .i_seek_one(1'b1),
        .o_position(ff1_pos)
    );

    // ****************************************************************
    // Effective address
    // ****************************************************************
    logic is_mem;
    logic is_xmem;
    logic xmem_bad;
    logic [1:0] scale;
    logic [31:0] index;
    logic [31:0] ea;
    assign is_mem = (i_op == BFAU_OP_LD) || (i_op == BFAU_OP_LDA)
                 || (i_op == BFAU_OP_ST) || (i_op == BFAU_OP_XMEM);
    assign is_xmem = (i_op == BFAU_OP_XMEM);
    // Exchange only moves bytes or words
    assign xmem_bad = is_xmem && (i_size != BFAU_SZ_BYTE)
                   && (i_size != BFAU_SZ_WORD);
    assign scale = (i_size == BFAU_SZ_BYTE) ? BFAU_SCALE_BYTE
                 : (i_size == BFAU_SZ_HALF) ? BFAU_SCALE_HALF
                 : (i_size == BFAU_SZ_WORD) ? BFAU_SCALE_WORD
                 : BFAU_SCALE_DBL;
    assign index = (i_addr_mode == BFAU_AM_IMM16) ? {16'h0000, i_imm16}
                 : (i_addr_mode == BFAU_AM_INDEX) ? i_second_source_reg
                 : (i_second_source_reg << scale);
    assign ea = i_first_source_reg + index;

    // ****************************************************************
    // Result select
    // ****************************************************************
    logic [31:0] res_d;
    logic known_op;
    always_comb begin
        res_d = BFAU_RESULT_RST;
        known_op = 1'b1;
        unique case (i_op)
            BFAU_OP_CLR: res_d = r_clr;
            BFAU_OP_SET: res_d = r_set;
            BFAU_OP_EXT: res_d = r_ext;
            BFAU_OP_EXTU: res_d = r_extu;
            BFAU_OP_FIND_FIRST_ZERO: res_d = {26'h0, ff0_pos};
            BFAU_OP_FIND_FIRST_ONE: res_d = {26'h0, ff1_pos};
            BFAU_OP_MAK: res_d = r_mak;
            BFAU_OP_ROT: res_d = r_rot;
            BFAU_OP_LD: res_d = BFAU_RESULT_RST;
            BFAU_OP_LDA: res_d = ea;
            BFAU_OP_ST: res_d = BFAU_RESULT_RST;
            BFAU_OP_XMEM: res_d = BFAU_RESULT_RST;
            default: known_op = 1'b0;
        endcase
    end

    // Register write happens for all legal ops but store, exchange and loads from memory
    logic wr_d;
    logic bad_d;
    assign bad_d = i_valid && (!known_op || xmem_bad);
    assign wr_d = i_valid && !bad_d && (!is_mem || i_op == BFAU_OP_LDA);

    // ****************************************************************
    // Output registers
    // ****************************************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_result_valid <= 1'b0;
            o_result <= BFAU_RESULT_RST;
            o_mem_valid <= 1'b0;
            o_mem_addr <= BFAU_RESULT_RST;
            o_mem_wdata <= BFAU_RESULT_RST;
            o_mem_write <= 1'b0;
            o_mem_read <= 1'b0;
            o_illegal <= 1'b0;
        end else begin
            o_result_valid <= wr_d;
            o_result <= res_d;
            o_mem_valid <= i_valid && is_mem && !bad_d
                        && (i_op != BFAU_OP_LDA);
            o_mem_addr <= ea;
            // Exchange sends the destination out and reads back into it
            o_mem_wdata <= i_dest_reg;
            o_mem_write <= (i_op == BFAU_OP_ST) || is_xmem;
            o_mem_read <= (i_op == BFAU_OP_LD) || is_xmem;
            o_illegal <= bad_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_clear_field: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && i_op == BFAU_OP_CLR |=> o_result_valid
        && o_result == ($past(src1) & ~$past(fmask)))
        else $error("clear result wrong");
    chk_set_field: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && i_op == BFAU_OP_SET |=>
        (o_result & $past(fmask)) == $past(fmask))
        else $error("set field not all ones");
    chk_full_width: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && i_op == BFAU_OP_EXTU && wraw == 5'h00 |=>
        o_result == ($past(src1) >> $past(offs)))
        else $error("zero width not full word");
    chk_ext_sign: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && i_op == BFAU_OP_EXT && wraw == 5'h00 |=>
        o_result == 32'($signed($past(src1)) >>> $past(offs)))
        else $error("signed extract wrong");
    // Register form judged from the raw operand, not the split wires
    chk_reg_fields: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && i_field_from_reg && i_op == BFAU_OP_EXTU
        && i_second_source_reg[9:5] == 5'h00 |=>
        o_result == ($past(src1) >> $past(i_second_source_reg[4:0])))
        else $error("register field split wrong");
    chk_ff_none: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && i_op == BFAU_OP_FIND_FIRST_ONE
        && i_second_source_reg == 32'h0 |=> o_result == 32'h20)
        else $error("find first one empty not 32");
    chk_ff0_top: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && i_op == BFAU_OP_FIND_FIRST_ZERO
        && !i_second_source_reg[31] |=> o_result == 32'h1f)
        else $error("find first zero top bit wrong");
    chk_rot_wrap: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && i_op == BFAU_OP_ROT |=> o_result ==
        (($past(src1) >> $past(offs))
        | ($past(src1) << (6'h20 - {1'b0, $past(offs)}))))
        else $error("rotate result wrong");
    chk_mak_low: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && i_op == BFAU_OP_MAK |=>
        (o_result & ~$past(fmask)) == 32'h0)
        else $error("make left stray bits");
    chk_scaled_ea: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && i_op == BFAU_OP_LDA && i_addr_mode == BFAU_AM_SCALED
        && i_size == BFAU_SZ_DBL |=> o_result == 32'($past(src1)
        + ($past(i_second_source_reg) << 3)))
        else $error("scaled address wrong");
    chk_xmem_size: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        i_valid && is_xmem && i_size == BFAU_SZ_HALF |=>
        o_illegal && !o_mem_valid)
        else $error("exchange half word accepted");
    chk_one_cycle: assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !i_valid |=> !o_result_valid && !o_mem_valid)
        else $error("result without issue");

endmodule

// File: rtl/bfau_pkg.sv
// Package of constants and types for the bit-field and address unit
package bfau_pkg;

    // ****************************************************************
    // Widths and field positions
    // ****************************************************************
    localparam int BFAU_XLEN = 32;
    localparam int BFAU_OFS_LSB = 0;
    localparam int BFAU_WID_LSB = 5;
    localparam logic [5:0] BFAU_FULL_WIDTH = 6'h20;
    localparam logic [5:0] BFAU_NONE_FOUND = 6'h20;
    localparam logic [31:0] BFAU_RESULT_RST = 32'h0000_0000;

    // ****************************************************************
    // Scale shifts by operand size
    // ****************************************************************
    localparam logic [1:0] BFAU_SCALE_BYTE = 2'h0;
    localparam logic [1:0] BFAU_SCALE_HALF = 2'h1;
    localparam logic [1:0] BFAU_SCALE_WORD = 2'h2;
    localparam logic [1:0] BFAU_SCALE_DBL = 2'h3;

    // ****************************************************************
    // Operation codes
    // ****************************************************************
    typedef enum logic [3:0] {
        BFAU_OP_CLR = 4'h0,
        BFAU_OP_SET = 4'h1,
        BFAU_OP_EXT = 4'h2,
        BFAU_OP_EXTU = 4'h3,
        BFAU_OP_FIND_FIRST_ZERO = 4'h4,
        BFAU_OP_FIND_FIRST_ONE = 4'h5,
        BFAU_OP_MAK = 4'h6,
        BFAU_OP_ROT = 4'h7,
        BFAU_OP_LD = 4'h8,
        BFAU_OP_LDA = 4'h9,
        BFAU_OP_ST = 4'ha,
        BFAU_OP_XMEM = 4'hb
    } bfau_op_t;

    // Address forms
    typedef enum logic [1:0] {
        BFAU_AM_IMM16 = 2'h0,
        BFAU_AM_INDEX = 2'h1,
        BFAU_AM_SCALED = 2'h2
    } bfau_amode_t;

    // Operand sizes
    typedef enum logic [1:0] {
        BFAU_SZ_BYTE = 2'h0,
        BFAU_SZ_HALF = 2'h1,
        BFAU_SZ_WORD = 2'h2,
        BFAU_SZ_DBL = 2'h3
    } bfau_size_t;

endpackage

// File: rtl/bfau_find_first.sv
// Priority scan from the top bit for the first bit of a chosen value
`timescale 1ns/1ps
module bfau_find_first
    import bfau_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Operand and polarity sought
    input wire logic [WIDTH-1:0] i_value,
    input wire logic i_seek_one,
    // Position found, 32 when none
    output logic [5:0] o_position
);

    // ****************************************************************
    // Scan
    // ****************************************************************
    logic [WIDTH-1:0] hits;
    assign hits = i_seek_one ? i_value : ~i_value;

    // Lowest index first, so the highest hit overwrites and wins
    always_comb begin
        o_position = BFAU_NONE_FOUND;
        for (int k = 0; k < WIDTH; k++) begin
            if (hits[k]) begin
                o_position = 6'(k);
            end
        end
    end

endmodule

// File: verif/bfau_rf_model.sv
// Register file write side model that keeps the last result written back and counts the writes
`timescale 1ns/1ps
module bfau_rf_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Write port from the unit
    input wire logic i_wr_en,
    input wire logic [31:0] i_wr_data,
    // Captured state
    output logic [31:0] o_last,
    output logic [7:0] o_count
);
    // One write a pulse; a stuck strobe shows up as an inflated count
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_last <= 32'h0;
            o_count <= 8'h0;
        end else if (i_wr_en) begin
            o_last <= i_wr_data;
            o_count <= o_count + 8'h1;
        end
    end
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the bit-field and address unit
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin tests_run++; \
    if ((act) !== (exp)) begin fails++; \
    $display("unexpected at %0t: %s", $time, msg); end end
module tb_top;
    import bfau_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic i_valid = 1'b0;
    logic [3:0] i_op = 4'h0;
    logic fr = 1'b0;
    logic [4:0] fw = 5'h0;
    logic [4:0] fo = 5'h0;
    logic [1:0] am = 2'h0;
    logic [1:0] sz = 2'h0;
    logic [15:0] imm = 16'h0;
    logic [31:0] s1 = 32'h0;
    logic [31:0] s2 = 32'h0;
    logic [31:0] dst = 32'h0;
    logic o_result_valid, o_mem_valid, o_mem_write, o_mem_read, o_illegal;
    logic [31:0] o_result, o_mem_addr, o_mem_wdata, rf_last;
    logic [7:0] rf_count;
    int fails = 0;
    int tests_run = 0;
    // Clock at 100 MHz
    initial begin
        forever #5 clk = ~clk;
    end
    bfau_unit DUT (.i_clk_sys(clk), .i_rst(rst), .i_valid(i_valid),
        .i_op(i_op), .i_field_from_reg(fr), .i_field_width(fw),
        .i_field_offset(fo), .i_addr_mode(am), .i_size(sz),
        .i_imm16(imm), .i_first_source_reg(s1), .i_second_source_reg(s2),
        .i_dest_reg(dst), .o_result_valid(o_result_valid),
        .o_result(o_result), .o_mem_valid(o_mem_valid),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
        .o_mem_write(o_mem_write), .o_mem_read(o_mem_read),
        .o_illegal(o_illegal));
    bfau_rf_model RF (.i_clk_sys(clk), .i_rst(rst),
        .i_wr_en(o_result_valid), .i_wr_data(o_result),
        .o_last(rf_last), .o_count(rf_count));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Issue one op, then look at the answer one cycle later
    task automatic run(input logic [3:0] op, input logic r,
        input logic [4:0] w, input logic [4:0] o, input logic [1:0] m,
        input logic [1:0] z, input logic [31:0] a, input logic [31:0] b);
        @(posedge clk);
        i_valid <= 1'b1;
        i_op <= op;
        fr <= r;
        fw <= w;
        fo <= o;
        am <= m;
        sz <= z;
        s1 <= a;
        s2 <= b;
        @(posedge clk);
        i_valid <= 1'b0;
        #1;
    endtask
    task automatic chk_res(input logic [31:0] exp);
        `CHK(o_result_valid, 1'b1, "no result strobe")
        `CHK(o_result, exp, "result value")
    endtask
    task automatic chk_mem(input logic [31:0] ad, input logic w);
        `CHK(o_mem_valid, 1'b1, "no memory strobe")
        `CHK(o_mem_addr, ad, "address value")
        `CHK(o_mem_write, w, "write flag")
        `CHK(o_mem_wdata, dst, "write data")
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_clr_set();
        run(BFAU_OP_CLR, 0, 4, 28, 0, 0, 32'hffff_ffff, 0);
        chk_res(32'h0fff_ffff);
        run(BFAU_OP_SET, 1, 0, 0, 0, 0, 0, {22'h0, 5'h8, 5'h4});
        chk_res(32'h0000_0ff0);
        run(BFAU_OP_SET, 0, 0, 0, 0, 0, 32'h0, 0);
        chk_res(32'hffff_ffff);
        $display("t_clr_set finished");
    endtask
    task automatic t_extract();
        run(BFAU_OP_EXT, 0, 4, 8, 0, 0, 32'h0000_0f00, 0);
        chk_res(32'hffff_ffff);
        run(BFAU_OP_EXTU, 0, 4, 8, 0, 0, 32'h0000_0f00, 0);
        chk_res(32'h0000_000f);
        run(BFAU_OP_EXT, 0, 0, 4, 0, 0, 32'h8000_0000, 0);
        chk_res(32'hf800_0000);
        run(BFAU_OP_EXTU, 1, 0, 0, 0, 0, 32'h8000_0000, 32'h1c);
        chk_res(32'h0000_0008);
        $display("t_extract finished");
    endtask
    task automatic t_find();
        run(BFAU_OP_FIND_FIRST_ZERO, 0, 0, 0, 0, 0, 0, 32'hffff_fff7);
        chk_res(32'h3);
        run(BFAU_OP_FIND_FIRST_ZERO, 0, 0, 0, 0, 0, 0, 32'hffff_ffff);
        chk_res({26'h0, BFAU_NONE_FOUND});
        run(BFAU_OP_FIND_FIRST_ONE, 0, 0, 0, 0, 0, 0, 32'h0000_1001);
        chk_res(32'hc);
        run(BFAU_OP_FIND_FIRST_ONE, 0, 0, 0, 0, 0, 0, 32'h0);
        chk_res(32'h20);
        $display("t_find finished");
    endtask
    task automatic t_mak_rot();
        run(BFAU_OP_MAK, 0, 4, 8, 0, 0, 32'h0000_00ff, 0);
        chk_res(32'h0000_0f00);
        run(BFAU_OP_MAK, 0, 0, 4, 0, 0, 32'hffff_ffff, 0);
        chk_res(32'hffff_fff0);
        run(BFAU_OP_ROT, 0, 0, 1, 0, 0, 32'h0000_0001, 0);
        chk_res(32'h8000_0000);
        run(BFAU_OP_ROT, 1, 0, 0, 0, 0, 32'h0000_0001, 32'h0000_03e4);
        chk_res(32'h1000_0000);
        $display("t_mak_rot finished");
    endtask
    task automatic t_addr();
        // Every size scales the index by its own shift
        for (int k = 0; k < 4; k++) begin
            run(BFAU_OP_LD, 0, 0, 0, BFAU_AM_SCALED, k[1:0], 32'h1000, 3);
            chk_mem(32'h1000 + (32'h3 << k), 1'b0);
            `CHK(o_mem_read, 1'b1, "load read")
        end
        @(posedge clk);
        imm <= 16'hffff;
        run(BFAU_OP_LDA, 0, 0, 0, BFAU_AM_IMM16, 0, 32'h1, 0);
        chk_res(32'h0001_0000);
        run(BFAU_OP_LDA, 0, 0, 0, BFAU_AM_SCALED, BFAU_SZ_DBL, 32'h10, 32'h2);
        chk_res(32'h0000_0020);
        @(posedge clk);
        dst <= 32'ha5a5_5a5a;
        run(BFAU_OP_ST, 0, 0, 0, BFAU_AM_INDEX, 3, 32'h100, 32'h20);
        chk_mem(32'h120, 1'b1);
        `CHK(o_mem_read, 1'b0, "store read")
        $display("t_addr finished");
    endtask
    task automatic t_xmem();
        run(BFAU_OP_XMEM, 0, 0, 0, BFAU_AM_SCALED, BFAU_SZ_WORD, 0, 2);
        chk_mem(32'h8, 1'b1);
        `CHK(o_mem_read, 1'b1, "exchange read")
        run(BFAU_OP_XMEM, 0, 0, 0, BFAU_AM_SCALED, BFAU_SZ_BYTE, 0, 2);
        chk_mem(32'h2, 1'b1);
        run(BFAU_OP_XMEM, 0, 0, 0, BFAU_AM_SCALED, BFAU_SZ_HALF, 0, 2);
        `CHK(o_illegal, 1'b1, "half exchange accepted")
        `CHK(o_mem_valid, 1'b0, "refused op accessed memory")
        $display("t_xmem finished");
    endtask
    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK(o_result, BFAU_RESULT_RST, "result after reset")
        t_clr_set();
        t_extract();
        t_find();
        t_mak_rot();
        t_addr();
        t_xmem();
        @(posedge clk);
        #1;
        `CHK(rf_count, 8'h11, "register write count")
        `CHK(rf_last, 32'h0000_0020, "last register write")
        test_done();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #20000;
        fails++;
        test_done();
    end
endmodule
